// ### verilog/gpcr_params.svh
// Constants for the graphics port configuration cycle router.
`ifndef GPCR_PARAMS_SVH
`define GPCR_PARAMS_SVH

// Processor I/O locations of the pointer and of the data window.
`define GPCR_PTR_IO_ADDR    16'h0CF8
`define GPCR_DATA_IO_ADDR   16'h0CFC
// Pointer reset value and the mask of bits that really store a value.
`define GPCR_PTR_RESET      32'h00000000
`define GPCR_PTR_KEEP_MASK  32'h80FFFFFC
// Pointer field positions.
`define GPCR_EN_BIT         31
`define GPCR_BUS_HI         23
`define GPCR_BUS_LO         16
`define GPCR_DEV_HI         15
`define GPCR_DEV_LO         11
`define GPCR_FREG_HI        10
`define GPCR_FREG_LO        2
// Full dword byte enable, primary bus number and Type 1 low address code.
`define GPCR_DWORD_BE       4'hF
`define GPCR_PRIMARY_BUS    8'h00
`define GPCR_TYPE1_LOW      2'h1
`define GPCR_TYPE0_LOW      2'h0

`endif

// ### verilog/gpcr_pkg.sv
// Types shared by the graphics port configuration cycle router.
package gpcr_pkg;

	// Sequencer states.
	typedef enum logic [1:0] {
		GPCR_IDLE     = 2'b00,
		GPCR_GFX_WAIT = 2'b01,
		GPCR_HUB_WAIT = 2'b10
	} gpcr_state_t;

	// Kind of cycle sent down the hub link.
	typedef enum logic [1:0] {
		GPCR_HUB_IO      = 2'b00,
		GPCR_HUB_CFG_T0  = 2'b01,
		GPCR_HUB_CFG_T1  = 2'b10
	} gpcr_hub_kind_t;

endpackage

// ### verilog/gpcr_cfg_ptr.sv
// Configuration address pointer storage with reserved bits held at zero.
`include "gpcr_params.svh"

module gpcr_cfg_ptr
	import gpcr_pkg::*;
(
	input  wire logic        clock,    // Core clock.
	input  wire logic        resetn,   // Asynchronous reset, active low.
	input  wire logic        wr_en,    // Dword write strobe.
	input  wire logic [31:0] wr_data,  // Value written by the processor.
	output logic      [31:0] ptr_q     // Stored pointer.
);

	logic [31:0] ptr_r;
	logic [31:0] ptr_nxt;

	// Reserved bits never store, so they always read back as zero.
	assign ptr_nxt = wr_en ? (wr_data & `GPCR_PTR_KEEP_MASK) : ptr_r;
	assign ptr_q   = ptr_r;

	// Pointer register, cleared by reset.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ptr_r <= `GPCR_PTR_RESET;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

endmodule

// ### verilog/gpcr_router.sv
// Translates processor configuration accesses into graphics or hub cycles.
//
// Notes on behaviour
// - Primary bus number of the graphics bridge always reads zero.
// - Non-zero bus number equal to secondary bus gives a Type 0 graphics cycle.
// - Device bits pick one-hot line 16+n; device 16 to 31 gives none.
// - Bus above secondary, up to subordinate, gives a Type 1 graphics cycle.
// - Pointer at I/O 0CF8h, 32 bits, resets to zero, dword read/write.
// - Byte or word accesses to the pointer go to the hub link as I/O.
// - Pointer bit 31 enables configuration access; bits 30:24 reserved.
// - Pointer holds bus, device, function and register of next access.
// - Data window reaches only the dword the pointer selects.
// - Fields map to address lines 23:16, 15:11, 10:8, 7:2; 1:0 reserved.
// - Type 0 with device above 15 runs without select; abort is reported.
// - Non-zero bus outside the graphics range goes to hub as Type 1.
// - Data window becomes a configuration access only while enabled.
`include "gpcr_params.svh"

module gpcr_router
	import gpcr_pkg::*;
#(
	parameter int IO_ADDR_W = 16
)(
	input  wire logic                 clock,          // Core clock.
	input  wire logic                 resetn,         // Async reset, low.
	input  wire logic                 io_req,         // Processor I/O strobe.
	input  wire logic                 io_write,       // 1 write, 0 read.
	input  wire logic [IO_ADDR_W-1:0] io_addr,        // I/O byte address.
	input  wire logic [3:0]           io_be,          // Byte enables.
	input  wire logic [31:0]          io_wdata,       // Write data.
	output logic                      io_ack,         // Answer pulse.
	output logic      [31:0]          io_rdata,       // Read data.
	output logic                      io_busy,        // Access in flight.
	input  wire logic [7:0]           sec_bus,        // Secondary bus number.
	input  wire logic [7:0]           sub_bus,        // Subordinate bus number.
	output logic      [7:0]           primary_bus,    // Primary bus number.
	output logic                      gfx_req,        // Graphics cycle pulse.
	output logic                      gfx_type1,      // 1 Type 1, 0 Type 0.
	output logic                      gfx_write,      // Config write.
	output logic      [31:0]          gfx_addr,       // Address lines.
	output logic      [3:0]           gfx_be,         // Byte enables.
	output logic      [31:0]          gfx_wdata,      // Write data.
	input  wire logic                 gfx_done,       // Cycle finished.
	input  wire logic                 gfx_abort,      // Finished by abort.
	input  wire logic [31:0]          gfx_rdata,      // Read data.
	output logic                      gfx_abort_rec,  // Abort to bridge status.
	output logic                      hub_link_req,   // Hub link pulse.
	output logic      [1:0]           hub_link_kind,  // Hub cycle kind.
	output logic                      hub_link_write, // Hub write.
	output logic      [31:0]          hub_link_addr,  // Hub address.
	output logic      [3:0]           hub_link_be,    // Hub byte enables.
	output logic      [31:0]          hub_link_wdata, // Hub write data.
	input  wire logic                 hub_link_done,  // Hub cycle finished.
	input  wire logic [31:0]          hub_link_rdata  // Hub read data.
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration check and helper functions.

	if (IO_ADDR_W < 16) begin : g_bad_width
		$error("gpcr_router: IO_ADDR_W must be at least 16");
	end

	// One-hot select from the device field; devices 16 and up select none.
	function automatic logic [15:0] idsel_of(input logic [4:0] dev);
		logic [15:0] sel;
		sel = 16'h0000;
		if (!dev[4]) begin
			sel[dev[3:0]] = 1'b1;
		end
		return sel;
	endfunction

	// Dword-aligned address compare used for both I/O locations.
	function automatic logic at_dword(input logic [IO_ADDR_W-1:0] a,
	                                  input logic [15:0] loc);
		return (a[IO_ADDR_W-1:2] == (IO_ADDR_W-2)'(loc[15:2]));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pointer and decode.

	logic [31:0] ptr_q;
	logic        ptr_wr;

	gpcr_cfg_ptr u_ptr (
		.clock   (clock),
		.resetn  (resetn),
		.wr_en   (ptr_wr),
		.wr_data (io_wdata),
		.ptr_q   (ptr_q)
	);

	gpcr_state_t state_r;
	gpcr_state_t state_nxt;

	wire       idle       = (state_r == GPCR_IDLE);
	wire       take       = io_req && idle;
	wire       hit_ptr    = at_dword(io_addr, `GPCR_PTR_IO_ADDR);
	wire       hit_data   = at_dword(io_addr, `GPCR_DATA_IO_ADDR);
	wire       is_dword   = (io_be == `GPCR_DWORD_BE);
	wire       ptr_local  = take && hit_ptr && is_dword;
	wire       cfg_en     = ptr_q[`GPCR_EN_BIT];
	wire       cfg_access = take && hit_data && cfg_en;
	wire [7:0] bus        = ptr_q[`GPCR_BUS_HI:`GPCR_BUS_LO];
	wire [4:0] dev        = ptr_q[`GPCR_DEV_HI:`GPCR_DEV_LO];
	wire       bus_zero   = (bus == 8'h00);
	wire       to_t0      = !bus_zero && (bus == sec_bus);
	wire       to_t1      = !bus_zero && (bus > sec_bus)
	                        && (bus <= sub_bus);
	wire       to_gfx     = cfg_access && (to_t0 || to_t1);

	assign ptr_wr = ptr_local && io_write;

	// Type 0 puts the select pattern on the upper lines; Type 1 carries the
	// whole target unchanged so the bridge further down can decode it.
	wire [31:0] t0_addr = {idsel_of(dev), 5'h00,
	                       ptr_q[`GPCR_FREG_HI:`GPCR_FREG_LO],
	                       `GPCR_TYPE0_LOW};
	wire [31:0] t1_addr = {8'h00, ptr_q[`GPCR_BUS_HI:`GPCR_FREG_LO],
	                       `GPCR_TYPE1_LOW};
	wire [31:0] io_addr32 = {{(32-16){1'b0}}, io_addr[15:0]};

	////////////////////////////////////////////////////////////////////////
	// Output registers.

	logic        io_ack_r,   io_ack_nxt;
	logic [31:0] io_rdata_r, io_rdata_nxt;
	logic        gfx_req_r,  gfx_req_nxt;
	logic        gfx_t1_r,   gfx_t1_nxt;
	logic        gfx_wr_r,   gfx_wr_nxt;
	logic [31:0] gfx_addr_r, gfx_addr_nxt;
	logic [3:0]  gfx_be_r,   gfx_be_nxt;
	logic [31:0] gfx_wd_r,   gfx_wd_nxt;
	logic        abort_r,    abort_nxt;
	logic        hub_req_r,  hub_req_nxt;
	logic [1:0]  hub_kind_r, hub_kind_nxt;
	logic        hub_wr_r,   hub_wr_nxt;
	logic [31:0] hub_addr_r, hub_addr_nxt;
	logic [3:0]  hub_be_r,   hub_be_nxt;
	logic [31:0] hub_wd_r,   hub_wd_nxt;
	logic [7:0]  prim_r;
	logic        busy_r;

	// Sequencer: one request at a time; new strobes while busy are ignored,
	// which keeps the pointer stable for the whole forwarded cycle.
	always_comb begin
		state_nxt    = state_r;
		io_ack_nxt   = 1'b0;
		io_rdata_nxt = io_rdata_r;
		gfx_req_nxt  = 1'b0;
		gfx_t1_nxt   = gfx_t1_r;
		gfx_wr_nxt   = gfx_wr_r;
		gfx_addr_nxt = gfx_addr_r;
		gfx_be_nxt   = gfx_be_r;
		gfx_wd_nxt   = gfx_wd_r;
		abort_nxt    = 1'b0;
		hub_req_nxt  = 1'b0;
		hub_kind_nxt = hub_kind_r;
		hub_wr_nxt   = hub_wr_r;
		hub_addr_nxt = hub_addr_r;
		hub_be_nxt   = hub_be_r;
		hub_wd_nxt   = hub_wd_r;
		case (state_r)
			GPCR_IDLE: begin
				if (ptr_local) begin
					io_ack_nxt   = 1'b1;
					io_rdata_nxt = io_write ? io_rdata_r : ptr_q;
				end else if (to_gfx) begin
					state_nxt    = GPCR_GFX_WAIT;
					gfx_req_nxt  = 1'b1;
					gfx_t1_nxt   = to_t1;
					gfx_wr_nxt   = io_write;
					gfx_addr_nxt = to_t1 ? t1_addr : t0_addr;
					gfx_be_nxt   = io_be;
					gfx_wd_nxt   = io_wdata;
				end else if (cfg_access) begin
					state_nxt    = GPCR_HUB_WAIT;
					hub_req_nxt  = 1'b1;
					hub_kind_nxt = bus_zero ? GPCR_HUB_CFG_T0
					                        : GPCR_HUB_CFG_T1;
					hub_wr_nxt   = io_write;
					hub_addr_nxt = bus_zero
					             ? {ptr_q[31:2], `GPCR_TYPE0_LOW}
					             : t1_addr;
					hub_be_nxt   = io_be;
					hub_wd_nxt   = io_wdata;
				end else if (take) begin
					// Partial pointer accesses, a disabled window and every
					// other location go down as plain I/O.
					state_nxt    = GPCR_HUB_WAIT;
					hub_req_nxt  = 1'b1;
					hub_kind_nxt = GPCR_HUB_IO;
					hub_wr_nxt   = io_write;
					hub_addr_nxt = io_addr32;
					hub_be_nxt   = io_be;
					hub_wd_nxt   = io_wdata;
				end
			end
			GPCR_GFX_WAIT: begin
				if (gfx_done) begin
					state_nxt    = GPCR_IDLE;
					io_ack_nxt   = 1'b1;
					io_rdata_nxt = gfx_wr_r ? io_rdata_r : gfx_rdata;
					abort_nxt    = gfx_abort;
				end
			end
			GPCR_HUB_WAIT: begin
				if (hub_link_done) begin
					state_nxt    = GPCR_IDLE;
					io_ack_nxt   = 1'b1;
					io_rdata_nxt = hub_wr_r ? io_rdata_r : hub_link_rdata;
				end
			end
			default: begin
				state_nxt = GPCR_IDLE;
			end
		endcase
	end

	// State and handshake flops.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_r     <= GPCR_IDLE;
			busy_r      <= 1'b0;
			io_ack_r    <= 1'b0;
			gfx_req_r   <= 1'b0;
			hub_req_r   <= 1'b0;
			abort_r     <= 1'b0;
			prim_r      <= `GPCR_PRIMARY_BUS;
		end else begin
			state_r     <= state_nxt;
			busy_r      <= (state_nxt != GPCR_IDLE); // Port straight from a flop.
			io_ack_r    <= io_ack_nxt;
			gfx_req_r   <= gfx_req_nxt;
			hub_req_r   <= hub_req_nxt;
			abort_r     <= abort_nxt;
			prim_r      <= `GPCR_PRIMARY_BUS;
		end
	end

	// Data-path flops.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			io_rdata_r  <= 32'h00000000;
			gfx_t1_r    <= 1'b0;
			gfx_wr_r    <= 1'b0;
			gfx_addr_r  <= 32'h00000000;
			gfx_be_r    <= 4'h0;
			gfx_wd_r    <= 32'h00000000;
			hub_kind_r  <= GPCR_HUB_IO;
			hub_wr_r    <= 1'b0;
			hub_addr_r  <= 32'h00000000;
			hub_be_r    <= 4'h0;
			hub_wd_r    <= 32'h00000000;
		end else begin
			io_rdata_r  <= io_rdata_nxt;
			gfx_t1_r    <= gfx_t1_nxt;
			gfx_wr_r    <= gfx_wr_nxt;
			gfx_addr_r  <= gfx_addr_nxt;
			gfx_be_r    <= gfx_be_nxt;
			gfx_wd_r    <= gfx_wd_nxt;
			hub_kind_r  <= hub_kind_nxt;
			hub_wr_r    <= hub_wr_nxt;
			hub_addr_r  <= hub_addr_nxt;
			hub_be_r    <= hub_be_nxt;
			hub_wd_r    <= hub_wd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port drivers, all straight from flops.

	assign io_ack         = io_ack_r;
	assign io_rdata       = io_rdata_r;
	assign io_busy        = busy_r;
	assign primary_bus    = prim_r;
	assign gfx_req        = gfx_req_r;
	assign gfx_type1      = gfx_t1_r;
	assign gfx_write      = gfx_wr_r;
	assign gfx_addr       = gfx_addr_r;
	assign gfx_be         = gfx_be_r;
	assign gfx_wdata      = gfx_wd_r;
	assign gfx_abort_rec  = abort_r;
	assign hub_link_req   = hub_req_r;
	assign hub_link_kind  = hub_kind_r;
	assign hub_link_write = hub_wr_r;
	assign hub_link_addr  = hub_addr_r;
	assign hub_link_be    = hub_be_r;
	assign hub_link_wdata = hub_wd_r;

endmodule

// ### tb/gpcr_router_chk.sv
// Checker bound to the router ports.
module gpcr_router_chk
	import gpcr_pkg::*;
#(
	parameter int IO_ADDR_W = 16
)(
	input wire logic                 clock,         // Clock.
	input wire logic                 resetn,        // Reset.
	input wire logic                 io_req,        // Request.
	input wire logic [IO_ADDR_W-1:0] io_addr,       // Address.
	input wire logic [3:0]           io_be,         // Enables.
	input wire logic                 io_busy,       // Busy.
	input wire logic                 io_ack,        // Answer.
	input wire logic [7:0]           sec_bus,       // Secondary.
	input wire logic [7:0]           sub_bus,       // Subordinate.
	input wire logic [7:0]           primary_bus,   // Primary.
	input wire logic                 gfx_req,       // Start.
	input wire logic                 gfx_type1,     // Type.
	input wire logic [31:0]          gfx_addr,      // Lines.
	input wire logic                 gfx_done,      // End.
	input wire logic                 gfx_abort,     // Abort.
	input wire logic                 gfx_abort_rec, // Status.
	input wire logic                 hub_link_req,  // Hub start.
	input wire logic [1:0]           hub_link_kind, // Hub kind.
	input wire logic                 hub_link_done  // Hub end.
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////
	// Pointer hit decode; one clock domain, so clocking is declared once.
	wire logic ptr_hit = io_req && !io_busy &&
		io_addr == IO_ADDR_W'(16'h0CF8);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	a_primary_zero: assert property (primary_bus == 8'h00)
		else $error("primary bus not zero");
	a_ptr_local: assert property (ptr_hit && io_be == 4'hF |=>
		io_ack && !io_busy && !gfx_req && !hub_link_req)
		else $error("dword pointer access not local");
	a_narrow_pass: assert property (ptr_hit && io_be != 4'hF |=>
		hub_link_req && hub_link_kind == 2'h0 && io_busy)
		else $error("narrow pointer access not passed on");
	a_idsel_onehot: assert property (gfx_req && !gfx_type1 |->
		$countones(gfx_addr[31:16]) <= 1 && gfx_addr[1:0] == 2'b00)
		else $error("bad type 0 address");
	a_type1_range: assert property (gfx_req && gfx_type1 |->
		gfx_addr[23:16] > sec_bus && gfx_addr[23:16] <= sub_bus &&
		gfx_addr[1:0] == 2'b01) else $error("bad type 1 cycle");
	a_abort_report: assert property (gfx_done && gfx_abort && io_busy
		|=> gfx_abort_rec) else $error("abort not reported");
	a_done_answer: assert property ((gfx_done || hub_link_done)
		&& io_busy |=> io_ack && !io_busy) else $error("no answer");
	a_start_busy: assert property ($rose(io_busy) |->
		gfx_req || hub_link_req) else $error("busy without a cycle");
endmodule

bind gpcr_router gpcr_router_chk #(.IO_ADDR_W(IO_ADDR_W)) u_gpcr_router_chk (
	.clock, .resetn, .io_req, .io_addr, .io_be, .io_busy, .io_ack, .sec_bus,
	.sub_bus, .primary_bus, .gfx_req, .gfx_type1, .gfx_addr, .gfx_done,
	.gfx_abort, .gfx_abort_rec, .hub_link_req, .hub_link_kind, .hub_link_done);

// ### tb/gpcr_far_model.sv
// Far-side model: graphics devices and the hub link answering cycles.
module gpcr_far_model (
	input wire logic        clock,          // Clock.
	input wire logic        resetn,         // Reset.
	input wire logic [3:0]  wait_cycles,    // Answer delay.
	input wire logic        gfx_req,        // Start.
	input wire logic        gfx_type1,      // Type.
	input wire logic [31:0] gfx_addr,       // Lines.
	output logic            gfx_done,       // End.
	output logic            gfx_abort,      // No target.
	output logic     [31:0] gfx_rdata,      // Data.
	input wire logic        hub_link_req,   // Hub start.
	input wire logic [1:0]  hub_link_kind,  // Hub kind.
	input wire logic [31:0] hub_link_addr,  // Hub address.
	output logic            hub_link_done,  // Hub end.
	output logic     [31:0] hub_link_rdata  // Hub data.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0]  cnt_r;
	logic        hub_r;
	logic [31:0] ans_r;
	////////////////////////////////////////
	// Answers echo the address, hub ones with the kind xored into bits 31:30, so the bench can judge the mapping; a Type 0
	// cycle with no select line finds no target and reads all ones.
	wire logic        fin = cnt_r == 5'h01;
	wire logic [31:0] gfx_ans = (!gfx_type1 && gfx_addr[31:16] == 16'h0000)
		? 32'hFFFFFFFF : gfx_addr;
	wire logic [31:0] hub_ans = hub_link_addr ^ {hub_link_kind, 30'h0};
	assign hub_link_rdata = gfx_rdata;

	// One cycle outstanding at a time; data toggles outside the answer.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 5'h00;
			gfx_done <= 1'b0;
			hub_link_done <= 1'b0;
			gfx_abort <= 1'b0;
			gfx_rdata <= 32'h00000000;
			hub_r <= 1'b0;
			ans_r <= 32'h00000000;
		end else begin
			gfx_done <= fin && !hub_r;
			hub_link_done <= fin && hub_r;
			gfx_abort <= fin && !hub_r && ans_r == 32'hFFFFFFFF;
			gfx_rdata <= fin ? ans_r : ~gfx_rdata;
			if (gfx_req || hub_link_req) begin
				cnt_r <= {1'b0, wait_cycles} + 5'h01;
				hub_r <= hub_link_req;
				ans_r <= hub_link_req ? hub_ans : gfx_ans;
			end else if (cnt_r != 5'h00)
				cnt_r <= cnt_r - 5'h01;
		end
	end
endmodule

// ### tb/graphics_port_config_cycle_router_tb.sv
// Bench of the configuration cycle router with its far-side model.
module graphics_port_config_cycle_router_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gpcr_pkg::*;

	// Inputs start defined; the answers come back as nets.
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic        io_req = 1'b0;
	logic        io_write = 1'b0;
	logic [15:0] io_addr = 16'h0000;
	logic [3:0]  io_be = 4'h0;
	logic [31:0] io_wdata = 32'h00000000;
	logic [7:0]  sec_bus = 8'h00;
	logic [7:0]  sub_bus = 8'h00;
	logic [3:0]  wait_cycles = 4'h0;
	logic        io_ack, io_busy, gfx_req, gfx_type1, gfx_write, gfx_done;
	logic        gfx_abort, gfx_abort_rec, hub_link_req, hub_link_write;
	logic        hub_link_done;
	logic [1:0]  hub_link_kind;
	logic [3:0]  gfx_be, hub_link_be;
	logic [7:0]  primary_bus;
	logic [31:0] io_rdata, gfx_addr, gfx_wdata, gfx_rdata, hub_link_addr;
	logic [31:0] hub_link_wdata, hub_link_rdata;
	int          n_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          n_aborts = 0;

	gpcr_router #(.IO_ADDR_W(16)) u_gpcr_router (.clock, .resetn, .io_req,
		.io_write, .io_addr, .io_be, .io_wdata, .io_ack, .io_rdata, .io_busy,
		.sec_bus, .sub_bus, .primary_bus, .gfx_req, .gfx_type1, .gfx_write,
		.gfx_addr, .gfx_be, .gfx_wdata, .gfx_done, .gfx_abort, .gfx_rdata,
		.gfx_abort_rec, .hub_link_req, .hub_link_kind, .hub_link_write,
		.hub_link_addr, .hub_link_be, .hub_link_wdata, .hub_link_done,
		.hub_link_rdata);
	gpcr_far_model u_gpcr_far_model (.clock, .resetn, .wait_cycles, .gfx_req,
		.gfx_type1, .gfx_addr, .gfx_done, .gfx_abort, .gfx_rdata,
		.hub_link_req, .hub_link_kind, .hub_link_addr, .hub_link_done,
		.hub_link_rdata);
	////////////////////////////////////////
	// Free-running clock; the cycle ceiling cuts a hang short.
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (gfx_abort_rec === 1'b1)
			n_aborts <= n_aborts + 1;
		if (cycles == 5000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic conclude();
		if (n_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One processor access: the strobe is a single pulse, the qualifiers
	// stay put until the answer, which is awaited under a bound.
	task automatic acc(input logic wr, input logic [15:0] a,
		input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		io_req <= 1'b1;
		io_write <= wr;
		io_addr <= a;
		io_be <= be;
		io_wdata <= wd;
		@(posedge clock);
		io_req <= 1'b0;
		#1;
		while (io_ack !== 1'b1 && n < 40) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("io_ack", 32'h00000001, 32'(io_ack));
		rd = io_rdata;
		@(posedge clock);
	endtask

	task automatic put_ptr(input logic [31:0] v);
		logic [31:0] t;
		acc(1'b1, 16'h0CF8, 4'hF, v, t);
	endtask

	task automatic win_rd(input logic [31:0] exp, input string what);
		logic [31:0] t;
		acc(1'b0, 16'h0CFC, 4'hF, 32'h00000000, t);
		chk(what, exp, t);
	endtask

	task automatic t_reset();
		logic [31:0] t;
		chk("primary bus", 32'h00000000, {24'h000000, primary_bus});
		acc(1'b0, 16'h0CF8, 4'hF, 32'h00000000, t);
		chk("pointer reset", 32'h00000000, t);
	endtask

	// Reserved bits stay clear; narrow accesses pass down untouched.
	task automatic t_ptr();
		logic [31:0] t;
		put_ptr(32'hFFFFFFFF);
		acc(1'b0, 16'h0CF8, 4'hF, 32'h00000000, t);
		chk("pointer mask", 32'h80FFFFFC, t);
		acc(1'b1, 16'h0CF8, 4'h3, 32'h00000000, t);
		acc(1'b0, 16'h0CF8, 4'h1, 32'h00000000, t);
		chk("byte read", 32'h00000CF8, t);
		acc(1'b0, 16'h0CF8, 4'hF, 32'h00000000, t);
		chk("pointer kept", 32'h80FFFFFC, t);
	endtask

	// Bus 0 is scanned before the bridge gets its bus numbers.
	task automatic t_enum();
		put_ptr(32'h80000A08);
		win_rd(32'hC0000A08, "bus zero");
		put_ptr(32'h00000A08);
		win_rd(32'h00000CFC, "window off");
		sec_bus <= 8'h05;
		sub_bus <= 8'h08;
	endtask

	task automatic t_type0();
		logic [4:0]  d;
		logic [31:0] e;
		for (int i = 0; i < 18; i++) begin
			d = (i == 17) ? 5'h1F : 5'(i);
			e = (d < 5'h10) ? {16'h0001 << d, 5'h00, 3'h2, 6'h0A, 2'b00}
				: 32'hFFFFFFFF;
			put_ptr({8'h80, 8'h05, d, 3'h2, 6'h0A, 2'b00});
			win_rd(e, "type 0 cycle");
		end
		// Let the last status pulse land in the counter before judging it.
		@(posedge clock);
		chk("abort pulses", 32'h00000002, 32'(n_aborts));
	endtask

	// Slow far side; both range edges, then buses below and above it.
	task automatic t_type1();
		logic [7:0]  bl [4] = '{8'h06, 8'h08, 8'h04, 8'h09};
		logic [31:0] e;
		logic [31:0] t;
		wait_cycles <= 4'h6;
		for (int i = 0; i < 4; i++) begin
			e = {8'h00, bl[i], 5'h03, 3'h1, 6'h3F, 2'b01};
			if (i > 1)
				e = e ^ 32'h80000000;
			put_ptr({8'h80, bl[i], 5'h03, 3'h1, 6'h3F, 2'b00});
			win_rd(e, "type 1 cycle");
		end
		acc(1'b1, 16'h0CFC, 4'hC, 32'h12345678, t);
		chk("hub data", 32'h12345678, hub_link_wdata);
		chk("hub write", 32'h00000001, 32'(hub_link_write));
		chk("hub enables", 32'h0000000C, 32'(hub_link_be));
		// A partial write inside the range reaches the graphics side as is.
		put_ptr({8'h80, 8'h06, 5'h03, 3'h1, 6'h3F, 2'b00});
		acc(1'b1, 16'h0CFC, 4'h3, 32'hA5A50F0F, t);
		chk("gfx data", 32'hA5A50F0F, gfx_wdata);
		chk("gfx write", 32'h00000001, 32'(gfx_write));
		chk("gfx enables", 32'h00000003, 32'(gfx_be));
	endtask

	initial begin
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		t_reset();
		t_ptr();
		t_enum();
		t_type0();
		t_type1();
		conclude();
	end
endmodule
